// file: dog_consts.vh
// register addresses, field positions, reset values and timing counts for the watchdog interval timer
`ifndef DOG_CONSTS_VH
`define DOG_CONSTS_VH
`define DOG_ADDR_CSR_W      32'hFFFFFE80
`define DOG_ADDR_CSR_R      32'hFFFFFE80
`define DOG_ADDR_CNT_R      32'hFFFFFE81
`define DOG_ADDR_RST_W      32'hFFFFFE82
`define DOG_ADDR_RST_R      32'hFFFFFE83
`define DOG_KEY_CNT         8'h5A
`define DOG_KEY_CSR         8'hA5
`define DOG_KEY_RST_CLR     8'hA5
`define DOG_KEY_RST_CFG     8'h5A
`define DOG_CSR_RESET       8'h18
`define DOG_CNT_RESET       8'h00
`define DOG_RST_RESET       8'h1F
`define DOG_CSR_ONES        8'h18
`define DOG_RST_ONES        8'h1F
`define DOG_BIT_FLAG        7
`define DOG_BIT_MODE        6
`define DOG_BIT_TME         5
`define DOG_BIT_CHIP_RESET_ENABLE        6
`define DOG_BIT_RESET_TYPE_SELECT        5
`define DOG_SIZE_BYTE       2'b00
`define DOG_SIZE_WORD       2'b01
`define DOG_SIZE_LONG       2'b10
`define DOG_PIN_CYCLES      10'd128
`define DOG_RST_CYCLES      10'd512
`define DOG_PRE_WIDTH       13
`endif

// file: dog_prescaler.v
// free-running prescaler giving a one-cycle tick on the selected tap
`timescale 1ns/1ps
`include "dog_consts.vh"
module dog_prescaler (
    input  wire       ref_clk_i,
    input  wire       rst_n_i,
    input  wire [2:0] sel_i,
    output reg        tick_o
);
    reg  [`DOG_PRE_WIDTH-1:0] div_ff;
    reg  [`DOG_PRE_WIDTH-1:0] mask;

    // tap masks for /2 /64 /128 /256 /512 /1024 /4096 /8192
    always @* begin
        case (sel_i)
            3'h0:    mask = 13'h0001;
            3'h1:    mask = 13'h003F;
            3'h2:    mask = 13'h007F;
            3'h3:    mask = 13'h00FF;
            3'h4:    mask = 13'h01FF;
            3'h5:    mask = 13'h03FF;
            3'h6:    mask = 13'h0FFF;
            default: mask = 13'h1FFF;
        endcase
    end

    // divider never resets mid-run, so the first tick after enable may come early
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ff <= 13'h0000;
            tick_o <= 1'b0;
        end else begin
            div_ff <= div_ff + 13'h0001;
            tick_o <= ((div_ff & mask) == mask); // [R21]
        end
    end
endmodule

// file: dog_unit.v
// watchdog / interval timer: keyed registers, counter, overflow and reset outputs
// What this block does
// [R1] eight-bit up-counter advances while enabled
// [R2] wrap drives overflow pin or interrupt
// [R3] counter clears on reset, disable; kept in standby
// [R4] status top bits clear; clock select survives standby
// [R5] interval flag set only in interval mode
// [R6] interval flag cleared by read-one-write-zero
// [R7] mode bit: 0 interval, 1 watchdog
// [R8] enable low holds counter at zero
// [R9] status bits 4,3 read one always
// [R10] clock select picks eight divide taps
// [R11] reset control loads 1F, not internal
// [R12] watchdog flag set only in watchdog mode
// [R13] watchdog flag cleared by read-write-zero
// [R14] chip reset enable; counter/status reset anyway
// [R15] type bit picks power-on or manual
// [R16] word writes only, byte reads only
// [R17] key 5A counter, A5 status
// [R18] A5 00 clears flag; 5A loads bits
// [R19] pin 128 cycles, reset 512 cycles
// [R20] type zero power-on, one manual
// [R21] counter steps on prescaler tick
// [R22] no new wrap pulse when disabled, one per wrap; interrupt stays while flag stands
`timescale 1ns/1ps
`include "dog_consts.vh"
module dog_unit (
    input  wire        ref_clk_i,
    input  wire        rst_n_i,
    input  wire        standby_i,
    input  wire        bus_wr_i,
    input  wire        bus_rd_i,
    input  wire [1:0]  bus_size_i,
    input  wire [31:0] bus_addr_i,
    input  wire [15:0] bus_wdata_i,
    output reg  [7:0]  bus_rdata_o,
    output reg         overflow_output_pin_n_o,
    output reg         interval_interrupt_o,
    output reg         power_on_reset_o,
    output reg         manual_reset_o
);
    reg        rst_s1_ff;
    reg        rst_s2_ff;
    reg  [7:0] dog_counter_ff;
    reg        interval_wrap_flag_ff;
    reg        mode_select_bit_ff;
    reg        count_enable_bit_ff;
    reg  [2:0] clock_select_ff;
    reg        watchdog_wrap_flag_ff;
    reg        chip_reset_enable_ff;
    reg        reset_type_select_ff;
    reg        iflag_seen_ff;
    reg        wflag_seen_ff;
    reg  [9:0] pin_cnt_ff;
    reg  [9:0] rst_cnt_ff;
    reg        rst_type_ff;
    wire       tick;
    wire       rst_n;
    wire       wrap;
    wire       dog_wrap;
    wire       word_wr;
    wire       byte_rd;
    wire       wr_csr_addr;
    wire       wr_rst_addr;
    wire       wr_cnt;
    wire       wr_csr;
    wire       wr_rst_clr;
    wire       wr_rst_cfg;
    wire [7:0] csr_view;
    wire [7:0] rst_view;

    assign rst_n = rst_s2_ff;

    // reset release through two flops
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    dog_prescaler u_pre (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .sel_i     (clock_select_ff), // [R10]
        .tick_o    (tick)
    );

    // bus decode: only word writes and byte reads are honoured
    assign word_wr     = bus_wr_i && (bus_size_i == `DOG_SIZE_WORD); // [R16]
    assign byte_rd     = bus_rd_i && (bus_size_i == `DOG_SIZE_BYTE); // [R16]
    assign wr_csr_addr = word_wr && (bus_addr_i == `DOG_ADDR_CSR_W);
    assign wr_rst_addr = word_wr && (bus_addr_i == `DOG_ADDR_RST_W);
    assign wr_cnt      = wr_csr_addr && (bus_wdata_i[15:8] == `DOG_KEY_CNT); // [R17]
    assign wr_csr      = wr_csr_addr && (bus_wdata_i[15:8] == `DOG_KEY_CSR); // [R17]
    assign wr_rst_clr  = wr_rst_addr && (bus_wdata_i == {`DOG_KEY_RST_CLR, 8'h00}); // [R18]
    assign wr_rst_cfg  = wr_rst_addr && (bus_wdata_i[15:8] == `DOG_KEY_RST_CFG); // [R18]

    // counter wraps only on a tick while running; a write beats the tick
    assign wrap     = count_enable_bit_ff && tick && !wr_cnt && (dog_counter_ff == 8'hFF); // [R2]
    assign dog_wrap = wrap && mode_select_bit_ff;

    assign csr_view = {interval_wrap_flag_ff, mode_select_bit_ff, count_enable_bit_ff,
                       2'b11, clock_select_ff}; // [R9]
    assign rst_view = {watchdog_wrap_flag_ff, chip_reset_enable_ff, reset_type_select_ff, 5'h1F};

    // counter: held at zero while disabled, kept through standby
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dog_counter_ff <= `DOG_CNT_RESET; // [R3]
        end else if (dog_wrap && !chip_reset_enable_ff) begin
            dog_counter_ff <= `DOG_CNT_RESET; // [R14]
        end else if (!count_enable_bit_ff && !standby_i) begin
            // standby clears the enable bit, but the count must survive until standby ends
            dog_counter_ff <= 8'h00; // [R8]
        end else if (wr_cnt) begin
            dog_counter_ff <= bus_wdata_i[7:0];
        end else if (tick && !standby_i) begin
            dog_counter_ff <= dog_counter_ff + 8'h01; // [R1]
        end
    end

    // control/status register; flag set wins over a concurrent clear
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            interval_wrap_flag_ff <= 1'b0;
            mode_select_bit_ff    <= 1'b0; // [R7]
            count_enable_bit_ff   <= 1'b0;
            clock_select_ff       <= 3'h0;
            iflag_seen_ff         <= 1'b0;
        end else if (standby_i || (dog_wrap && !chip_reset_enable_ff)) begin
            interval_wrap_flag_ff <= 1'b0; // [R4]
            mode_select_bit_ff    <= 1'b0;
            count_enable_bit_ff   <= 1'b0;
            iflag_seen_ff         <= 1'b0;
        end else begin
            if (byte_rd && (bus_addr_i == `DOG_ADDR_CSR_R) && interval_wrap_flag_ff) begin
                iflag_seen_ff <= 1'b1;
            end
            if (wrap && !mode_select_bit_ff) begin
                interval_wrap_flag_ff <= 1'b1; // [R5]
            end else if (wr_csr && iflag_seen_ff && !bus_wdata_i[`DOG_BIT_FLAG]) begin
                interval_wrap_flag_ff <= 1'b0; // [R6]
                iflag_seen_ff         <= 1'b0;
            end
            if (wr_csr) begin
                mode_select_bit_ff  <= bus_wdata_i[`DOG_BIT_MODE];
                count_enable_bit_ff <= bus_wdata_i[`DOG_BIT_TME];
                clock_select_ff     <= bus_wdata_i[2:0];
            end
        end
    end

    // reset control register: only the external pin and standby reload it
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_wrap_flag_ff <= 1'b0; // [R11]
            chip_reset_enable_ff  <= 1'b0;
            reset_type_select_ff  <= 1'b0; // [R20]
            wflag_seen_ff         <= 1'b0;
        end else if (standby_i) begin
            watchdog_wrap_flag_ff <= 1'b0; // [R11]
            chip_reset_enable_ff  <= 1'b0;
            reset_type_select_ff  <= 1'b0;
            wflag_seen_ff         <= 1'b0;
        end else begin
            if (byte_rd && (bus_addr_i == `DOG_ADDR_RST_R) && watchdog_wrap_flag_ff) begin
                wflag_seen_ff <= 1'b1;
            end
            if (dog_wrap) begin
                watchdog_wrap_flag_ff <= 1'b1; // [R12]
            end else if (wr_rst_clr && wflag_seen_ff) begin
                watchdog_wrap_flag_ff <= 1'b0; // [R13]
                wflag_seen_ff         <= 1'b0;
            end
            if (wr_rst_cfg) begin
                chip_reset_enable_ff <= bus_wdata_i[`DOG_BIT_CHIP_RESET_ENABLE]; // [R18]
                reset_type_select_ff <= bus_wdata_i[`DOG_BIT_RESET_TYPE_SELECT];
            end
        end
    end

    // pulse-width counters for the overflow pin and internal reset
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_cnt_ff  <= 10'd0;
            rst_cnt_ff  <= 10'd0;
            rst_type_ff <= 1'b0;
        end else begin
            if (dog_wrap) begin
                pin_cnt_ff <= `DOG_PIN_CYCLES; // [R19]
            end else if (pin_cnt_ff != 10'd0) begin
                pin_cnt_ff <= pin_cnt_ff - 10'd1;
            end
            if (dog_wrap && chip_reset_enable_ff) begin
                rst_cnt_ff  <= `DOG_RST_CYCLES; // [R19]
                rst_type_ff <= reset_type_select_ff; // [R15]
            end else if (rst_cnt_ff != 10'd0) begin
                rst_cnt_ff <= rst_cnt_ff - 10'd1;
            end
        end
    end

    // registered outputs; interrupt is a level held while the flag stands
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            overflow_output_pin_n_o <= 1'b1;
            interval_interrupt_o    <= 1'b0;
            power_on_reset_o        <= 1'b0;
            manual_reset_o          <= 1'b0;
            bus_rdata_o             <= 8'h00;
        end else begin
            overflow_output_pin_n_o <= !(dog_wrap || (pin_cnt_ff > 10'd1)); // [R22]
            interval_interrupt_o    <= interval_wrap_flag_ff || (wrap && !mode_select_bit_ff); // [R2]
            power_on_reset_o        <= ((dog_wrap && chip_reset_enable_ff && !reset_type_select_ff) ||
                                        ((rst_cnt_ff > 10'd1) && !rst_type_ff)); // [R14]
            manual_reset_o          <= ((dog_wrap && chip_reset_enable_ff && reset_type_select_ff) ||
                                        ((rst_cnt_ff > 10'd1) && rst_type_ff)); // [R15]
            // read address decode, byte reads only
            if (byte_rd && (bus_addr_i == `DOG_ADDR_CSR_R)) begin
                bus_rdata_o <= csr_view;
            end else if (byte_rd && (bus_addr_i == `DOG_ADDR_CNT_R)) begin
                bus_rdata_o <= dog_counter_ff;
            end else if (byte_rd && (bus_addr_i == `DOG_ADDR_RST_R)) begin
                bus_rdata_o <= rst_view;
            end else begin
                bus_rdata_o <= 8'h00;
            end
        end
    end
endmodule

// file: cpu_bus_model.sv
// cpu-side bus master model: writes and reads of the size given by the caller, with one-cycle strobes
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire        ref_clk_i,
    input  wire [7:0]  bus_rdata_i,
    output reg         bus_wr_o = 1'b0,
    output reg         bus_rd_o = 1'b0,
    output reg  [1:0]  bus_size_o = 2'b00,
    output reg  [31:0] bus_addr_o = 32'h00000000,
    output reg  [15:0] bus_wdata_o = 16'h0000
);
    // request changes just after an edge and holds until the taking edge
    task acc(input w, input [31:0] a, input [15:0] d, input [1:0] s, output [7:0] q);
        begin
            @(posedge ref_clk_i);
            #1;
            bus_addr_o = a;
            bus_wdata_o = d;
            bus_size_o = s;
            bus_wr_o = w;
            bus_rd_o = !w;
            @(posedge ref_clk_i);
            #1;
            q = bus_rdata_i;
            bus_wr_o = 1'b0;
            bus_rd_o = 1'b0;
            bus_wdata_o = ~d; // stale data never looks valid
        end
    endtask
endmodule

// file: dog_unit_props.sv
// concurrent checks on the watchdog interval timer ports
`timescale 1ns/1ps
`include "dog_consts.vh"
module dog_unit_props (
    input wire        ref_clk_i,
    input wire        rst_n_i,
    input wire        standby_i,
    input wire        bus_wr_i,
    input wire        bus_rd_i,
    input wire [1:0]  bus_size_i,
    input wire [31:0] bus_addr_i,
    input wire [15:0] bus_wdata_i,
    input wire [7:0]  bus_rdata_o,
    input wire        overflow_output_pin_n_o,
    input wire        interval_interrupt_o,
    input wire        power_on_reset_o,
    input wire        manual_reset_o
);
    wire       rst_any = power_on_reset_o | manual_reset_o;
    wire       rd_b    = bus_rd_i && (bus_size_i == `DOG_SIZE_BYTE);
    reg  [9:0] hi_cnt_ff;
    // cycles the internal reset has stood so far; too long for a repetition
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            hi_cnt_ff <= 10'h000;
        else
            hi_cnt_ff <= rst_any ? hi_cnt_ff + 10'h001 : 10'h000;
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_pin_span;
        ##127 !overflow_output_pin_n_o ##1 overflow_output_pin_n_o;
    endsequence
    a_pin_low_span: assert property ($fell(overflow_output_pin_n_o) |-> s_pin_span)
        else $error("overflow pin low time wrong");
    a_reset_length: assert property ($fell(rst_any) |-> hi_cnt_ff == 10'h200)
        else $error("internal reset length wrong");
    a_reset_with_pin: assert property ($rose(rst_any) |-> $fell(overflow_output_pin_n_o))
        else $error("internal reset not aligned with pin");
    a_one_reset_kind: assert property (!(power_on_reset_o && manual_reset_o))
        else $error("both reset kinds raised");
    a_bad_read_zero: assert property (bus_rd_i && !rd_b |=> bus_rdata_o == 8'h00)
        else $error("wide read returned data");
    a_csr_fixed_ones: assert property (rd_b && bus_addr_i == `DOG_ADDR_CSR_R |=> bus_rdata_o[4:3] == 2'h3)
        else $error("status fixed bits wrong");
    a_rst_low_ones: assert property (rd_b && bus_addr_i == `DOG_ADDR_RST_R |=> bus_rdata_o[4:0] == 5'h1F)
        else $error("reset control fixed bits wrong");
    a_mode_exclusive: assert property ($rose(interval_interrupt_o) |-> overflow_output_pin_n_o && !rst_any)
        else $error("interrupt with watchdog outputs");
endmodule
bind dog_unit dog_unit_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_size_i(bus_size_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .overflow_output_pin_n_o(overflow_output_pin_n_o),
    .interval_interrupt_o(interval_interrupt_o), .power_on_reset_o(power_on_reset_o),
    .manual_reset_o(manual_reset_o));

// file: test_dog_unit.sv
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
`include "dog_consts.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %0s expected %h seen %h", nm, e, g); end end
module test_dog_unit;
    localparam [31:0] CSW = `DOG_ADDR_CSR_W;
    localparam [31:0] CNR = `DOG_ADDR_CNT_R;
    localparam [31:0] RSW = `DOG_ADDR_RST_W;
    localparam [31:0] RSR = `DOG_ADDR_RST_R;
    reg         ref_clk_i = 1'b0;
    reg         rst_n_i   = 1'b0;
    reg         standby_i = 1'b0;
    wire        bwr, brd, pin_n, irq, por, mrst;
    wire [1:0]  sz;
    wire [31:0] ad;
    wire [15:0] wd;
    wire [7:0]  rdat;
    int         mismatches = 0;
    int         check_count = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    cpu_bus_model m (.ref_clk_i(ref_clk_i), .bus_rdata_i(rdat), .bus_wr_o(bwr), .bus_rd_o(brd),
        .bus_size_o(sz), .bus_addr_o(ad), .bus_wdata_o(wd));
    dog_unit uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i), .bus_wr_i(bwr),
        .bus_rd_i(brd), .bus_size_i(sz), .bus_addr_i(ad), .bus_wdata_i(wd), .bus_rdata_o(rdat),
        .overflow_output_pin_n_o(pin_n), .interval_interrupt_o(irq), .power_on_reset_o(por),
        .manual_reset_o(mrst));
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task wr(input [31:0] a, input [15:0] d, input [1:0] s = `DOG_SIZE_WORD);
        reg [7:0] q;
        m.acc(1'b1, a, d, s, q);
    endtask
    task rdc(input [31:0] a, input [7:0] e, input string nm, input [1:0] s = `DOG_SIZE_BYTE);
        reg [7:0] q;
        begin
            m.acc(1'b0, a, 16'h0000, s, q);
            `CHK(nm, e, q)
        end
    endtask
    // bounded wait for the interrupt (sel 1) or the pin (sel 0)
    task wt(input sel);
        int n;
        begin
            for (n = 0; n < 2000 && (sel ? irq : !pin_n) !== 1'b1; n++)
                @(posedge ref_clk_i);
            #1;
            if (n == 2000) begin
                mismatches++;
                close_out;
            end
        end
    endtask
    task t_regs;
        int c;
        begin
            rdc(CSW, 8'h18, "status");
            rdc(CNR, 8'h00, "counter");
            rdc(RSR, 8'h1F, "reset control");
            rdc(32'hFFFFFE84, 8'h00, "unmapped");
            rdc(CSW, 8'h00, "word read", `DOG_SIZE_WORD);
            for (c = 0; c < 8; c++) begin
                wr(CSW, {8'hA5, 5'h00, c[2:0]});
                rdc(CSW, {5'h03, c[2:0]}, "clock select");
            end
            $display("regs done");
        end
    endtask
    task t_counter;
        begin
            wr(CSW, 16'h5A33);
            rdc(CNR, 8'h00, "held counter");
            wr(CSW, 16'hA527);
            wr(CSW, 16'h5A33);
            rdc(CNR, 8'h33, "loaded counter");
            wr(CSW, 16'h5A44, `DOG_SIZE_BYTE);
            wr(CSW, 16'h5A55, `DOG_SIZE_LONG);
            wr(CSW, 16'h1266);
            rdc(CNR, 8'h33, "refused writes");
            rdc(CSW, 8'h3F, "status");
            wr(CSW, 16'hA507);
            rdc(CNR, 8'h00, "cleared counter");
            $display("counter done");
        end
    endtask
    task t_interval;
        begin
            wr(CSW, 16'hA520); // interval mode, enabled, fastest tap
            wr(CSW, 16'h5AFE);
            wt(1'b1);
            `CHK("pin", 1'b1, pin_n)
            rdc(CSW, 8'hB8, "flagged status");
            rdc(RSR, 8'h1F, "no dog flag");
            wr(CSW, 16'hA520);
            rdc(CSW, 8'h38, "cleared status");
            `CHK("interrupt", 1'b0, irq)
            wr(CSW, 16'hA5A0);
            rdc(CSW, 8'h38, "flag write one");
            wr(CSW, 16'hA500);
            $display("interval done");
        end
    endtask
    task t_dog;
        reg [7:0] cf;
        int k;
        begin
            for (k = 0; k < 3; k++) begin
                cf = (k == 0) ? 8'h40 : (k == 1) ? 8'h60 : 8'h00;
                wr(RSW, {8'h5A, cf});
                wr(CSW, 16'hA560);
                wr(CSW, 16'h5AFE);
                wt(1'b0);
                `CHK("power-on reset", k == 0, por)
                `CHK("manual reset", k == 1, mrst)
                `CHK("interrupt", 1'b0, irq)
                if (k == 2)
                    rdc(CSW, 8'h18, "status after wrap");
                wr(CSW, 16'hA500);
                rdc(RSR, cf | 8'h9F, "dog flag");
                wr(RSW, 16'hA500);
                rdc(RSR, cf | 8'h1F, "cleared flag");
                repeat (520) @(posedge ref_clk_i);
            end
            $display("watchdog done");
        end
    endtask
    task t_standby;
        begin
            wr(RSW, 16'h5A60);
            wr(CSW, 16'hA567);
            wr(CSW, 16'h5A40);
            standby_i = 1'b1;
            rdc(CSW, 8'h1F, "standby status");
            rdc(CNR, 8'h40, "standby counter");
            rdc(RSR, 8'h1F, "standby reset control");
            standby_i = 1'b0;
            rdc(CNR, 8'h00, "counter after standby");
            $display("standby done");
        end
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_regs;
        t_counter;
        t_interval;
        t_dog;
        t_standby;
        close_out;
    end
endmodule
